//--- rtl/lpm_pkg.sv
package lpm_pkg;

   // Operating modes of the device
   typedef enum logic [2:0] {
      LPM_RUN,
      LPM_SLEEP,
      LPM_STOP0,
      LPM_STOP1,
      LPM_STBY_RET,
      LPM_STBY
   } lpm_mode_type;

   // Low-power mode selection codes given with the entry request
   localparam logic [2:0] LP_SEL_SLEEP    = 3'h1;
   localparam logic [2:0] LP_SEL_STOP0    = 3'h2;
   localparam logic [2:0] LP_SEL_STOP1    = 3'h3;
   localparam logic [2:0] LP_SEL_STBY_RET = 3'h4;
   localparam logic [2:0] LP_SEL_STBY     = 3'h5;

   // Sizes
   localparam int SRAM_BANKS = 2;
   localparam int WAKE_PINS  = 8;
   localparam int IO_COUNT   = 20;
   localparam int AUTO_PERIS = 6;
   localparam int SYNC_W     = WAKE_PINS + 1;

   // Autonomous peripheral positions in request and wake vectors
   localparam int P_SERIAL   = 0;
   localparam int P_LPSERIAL = 1;
   localparam int P_I2C      = 2;
   localparam int P_SPI      = 3;
   localparam int P_ADC      = 4;
   localparam int P_LPTIM    = 5;

   // Reset values
   localparam logic RST_FLASH_PD   = 1'b0;
   localparam logic RST_IO_ANALOG  = 1'b1;
   localparam logic RST_RST_PULLUP = 1'b1;

endpackage

//--- rtl/lpm_sync.sv
`timescale 1ns/100ps

module lpm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rstn,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;

   // Two flops; the first one feeds only the second
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // lpm_sync

//--- rtl/lpm_ctrl.sv
`timescale 1ns/100ps

// What this block does
// - Flash power-down is optional, chosen by software, off after reset.
// - Each SRAM bank has its own power switch set by software.
// - Fast internal oscillator starts on peripheral request in stop 1, stops after; always on in stop 0.
// - External oscillator runs while radio requests it in run, sleep and stop 0; off in stop 1 and standby.
// - Eight wake-up pins in standby, each enabled by software.
// - In standby I/O levels held by pull-up, pull-down, or left floating.
// - Serial ports work in stop in async or SPI master mode, wake on events.
// - Autonomous I2C port works in stop and wakes on transfer events.
// - Autonomous SPI port works in stop and wakes on transfer events.
// - Analog converter works in stop and wakes on conversion events.
// - Low-power timer runs in stop and wakes on its events.
// - DMA works in stop 0 and wakes on events; only retains in stop 1.
// - In standby debug unit reachable only while debugger requests power-up.
// - During and after reset all I/Os analog with Schmitt input off.
// - Reset pin pull-up switched off when reset source is internal.
// - Optional functions off by default; retained keep state; others off.
// - Retained SRAM parity error wakes from stop via parity irq or NMI.
// - Without bus clock requests, return to stop 1 if stop 1 selected.

module lpm_ctrl (
   // Clock and reset
   input  wire logic                              clock,
   input  wire logic                              rstn,
   // Software mode control
   input  wire logic                              lp_enter,
   input  wire logic [2:0]                        lp_sel,
   input  wire logic                              flash_pd_en,
   input  wire logic [lpm_pkg::SRAM_BANKS-1:0]    sram_bank_en,
   input  wire logic                              hse_sw_en,
   // Autonomous peripherals
   input  wire logic [lpm_pkg::AUTO_PERIS-1:0]    peri_en,
   input  wire logic [lpm_pkg::AUTO_PERIS-1:0]    peri_wake_en,
   input  wire logic [lpm_pkg::AUTO_PERIS-1:0]    peri_wake_irq,
   input  wire logic [lpm_pkg::AUTO_PERIS-1:0]    peri_hsi_req,
   input  wire logic [1:0]                        serial_mode_ok,
   input  wire logic                              bus_clk_req,
   input  wire logic                              radio_hse_req,
   input  wire logic                              dma_en,
   input  wire logic                              dma_wake_en,
   input  wire logic                              dma_wake_irq,
   // SRAM parity
   input  wire logic                              sram_parity_err,
   input  wire logic                              parity_irq_en,
   input  wire logic                              parity_nmi_en,
   // Wake-up pins and I/O retention
   input  wire logic [lpm_pkg::WAKE_PINS-1:0]     wake_pin,
   input  wire logic [lpm_pkg::WAKE_PINS-1:0]     wake_pin_en,
   input  wire logic                              io_retain_en,
   input  wire logic [lpm_pkg::IO_COUNT-1:0]      io_level,
   input  wire logic                              io_config_done,
   input  wire logic                              io_release,
   // Debug and reset source
   input  wire logic                              debug_power_up_request,
   input  wire logic                              reset_internal,
   // Mode and power outputs
   output lpm_pkg::lpm_mode_type                  mode_reg,
   output logic                                   cpu_clk_on_reg,
   output logic                                   sys_clk_on_reg,
   output logic                                   flash_pd_reg,
   output logic [lpm_pkg::SRAM_BANKS-1:0]         sram_power_reg,
   output logic                                   internal_fast_oscillator_on_reg,
   output logic                                   external_fast_oscillator_on_reg,
   // Peripheral state outputs
   output logic [lpm_pkg::AUTO_PERIS-1:0]         peri_run_reg,
   output logic                                   dma_run_reg,
   output logic                                   dma_retain_reg,
   output logic                                   wake_event_reg,
   output logic                                   parity_wake_reg,
   // I/O and debug outputs
   output logic                                   io_analog_reg,
   output logic                                   io_schmitt_en_reg,
   output logic [lpm_pkg::IO_COUNT-1:0]           io_pull_up_reg,
   output logic [lpm_pkg::IO_COUNT-1:0]           io_pull_down_reg,
   output logic                                   reset_pullup_en_reg,
   output logic                                   debug_access_port_zero_reg
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and helpers

   logic [lpm_pkg::SYNC_W-1:0]    sync_bus;
   logic [lpm_pkg::WAKE_PINS-1:0] wake_pin_s;
   logic                          dbg_req_s;
   lpm_pkg::lpm_mode_type         mode_next;
   logic                          in_stop;
   logic                          in_stby;
   logic                          peri_wake;
   logic                          dma_wake;
   logic                          parity_wake;
   logic                          pin_wake;
   logic [lpm_pkg::AUTO_PERIS-1:0] peri_ok;

   // Pins from outside the clock domain
   lpm_sync #(
      .W (lpm_pkg::SYNC_W)
   ) u_sync (
      .clock    (clock),
      .rstn     (rstn),
      .async_in ({debug_power_up_request, wake_pin}),
      .sync_out (sync_bus)
   );

   assign wake_pin_s = sync_bus[lpm_pkg::WAKE_PINS-1:0];
   assign dbg_req_s  = sync_bus[lpm_pkg::WAKE_PINS];

   // Mode class decode, used in several places
   function automatic logic is_stop(input lpm_pkg::lpm_mode_type m);
      is_stop = (m == lpm_pkg::LPM_STOP0) || (m == lpm_pkg::LPM_STOP1);
   endfunction

   function automatic logic is_stby(input lpm_pkg::lpm_mode_type m);
      is_stby = (m == lpm_pkg::LPM_STBY_RET) || (m == lpm_pkg::LPM_STBY);
   endfunction

   assign in_stop = is_stop(mode_reg);
   assign in_stby = is_stby(mode_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Wake-up sources

   // Serial ports stay usable in stop only in async or SPI master mode
   always_comb begin
      peri_ok = peri_en;
      peri_ok[lpm_pkg::P_SERIAL]   = peri_en[lpm_pkg::P_SERIAL] &
                                     serial_mode_ok[0];
      peri_ok[lpm_pkg::P_LPSERIAL] = peri_en[lpm_pkg::P_LPSERIAL] &
                                     serial_mode_ok[1];
   end

   // Wake enables default to off, so optional wake stays dormant
   assign peri_wake   = |(peri_wake_irq & peri_wake_en & peri_ok);
   assign dma_wake    = dma_wake_irq & dma_wake_en & dma_en &
                        (mode_reg == lpm_pkg::LPM_STOP0);
   assign parity_wake = sram_parity_err &
                        (parity_irq_en | parity_nmi_en);
   assign pin_wake    = |(wake_pin_s & wake_pin_en);

   ////////////////////////////////////////////////////////////////////////////
   // Mode state machine

   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         lpm_pkg::LPM_RUN: begin
            if (lp_enter) begin
               unique case (lp_sel)
                  lpm_pkg::LP_SEL_SLEEP:    mode_next = lpm_pkg::LPM_SLEEP;
                  lpm_pkg::LP_SEL_STOP0:    mode_next = lpm_pkg::LPM_STOP0;
                  lpm_pkg::LP_SEL_STOP1:    mode_next = lpm_pkg::LPM_STOP1;
                  lpm_pkg::LP_SEL_STBY_RET: mode_next = lpm_pkg::LPM_STBY_RET;
                  lpm_pkg::LP_SEL_STBY:     mode_next = lpm_pkg::LPM_STBY;
                  default:                  mode_next = lpm_pkg::LPM_RUN;
               endcase
            end
         end
         lpm_pkg::LPM_SLEEP: begin
            if (peri_wake || dma_wake_irq || parity_wake) begin
               mode_next = lpm_pkg::LPM_RUN;
            end
         end
         lpm_pkg::LPM_STOP0: begin
            if (peri_wake || dma_wake || parity_wake) begin
               mode_next = lpm_pkg::LPM_RUN;
            end else if (!bus_clk_req &&
                         lp_sel == lpm_pkg::LP_SEL_STOP1) begin
               mode_next = lpm_pkg::LPM_STOP1;
            end
         end
         lpm_pkg::LPM_STOP1: begin
            if (peri_wake || parity_wake) begin
               mode_next = lpm_pkg::LPM_RUN;
            end else if (bus_clk_req) begin
               mode_next = lpm_pkg::LPM_STOP0;
            end
         end
         lpm_pkg::LPM_STBY_RET, lpm_pkg::LPM_STBY: begin
            if (pin_wake) begin
               mode_next = lpm_pkg::LPM_RUN;
            end
         end
      endcase
   end

   // Mode register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= lpm_pkg::LPM_RUN;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Wake pulse marks the cycle in which a low-power mode is left
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wake_event_reg  <= 1'b0;
         parity_wake_reg <= 1'b0;
      end else begin
         wake_event_reg  <= (mode_reg != lpm_pkg::LPM_RUN) &&
                            (mode_next == lpm_pkg::LPM_RUN);
         parity_wake_reg <= in_stop && parity_wake;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clocks and oscillators

   // System clock follows the next mode so it is back with the wake
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cpu_clk_on_reg <= 1'b1;
         sys_clk_on_reg <= 1'b1;
      end else begin
         cpu_clk_on_reg <= (mode_next == lpm_pkg::LPM_RUN);
         sys_clk_on_reg <= (mode_next == lpm_pkg::LPM_RUN) ||
                           (mode_next == lpm_pkg::LPM_SLEEP) ||
                           (mode_next == lpm_pkg::LPM_STOP0);
      end
   end

   // Fast oscillators; in stop 1 the internal one lives only on demand and the external one stays off
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         internal_fast_oscillator_on_reg <= 1'b1;
         external_fast_oscillator_on_reg <= 1'b0;
      end else begin
         if (is_stop(mode_next)) begin
            internal_fast_oscillator_on_reg <=
               |(peri_hsi_req & peri_ok) ||
               (mode_next == lpm_pkg::LPM_STOP0);
         end else begin
            internal_fast_oscillator_on_reg <= !is_stby(mode_next);
         end
         if (mode_next == lpm_pkg::LPM_STOP0) begin
            external_fast_oscillator_on_reg <= radio_hse_req;
         end else if (is_stop(mode_next) || is_stby(mode_next)) begin
            external_fast_oscillator_on_reg <= 1'b0;
         end else begin
            external_fast_oscillator_on_reg <= hse_sw_en | radio_hse_req;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memories

   // Flash power-down and independent SRAM switches
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flash_pd_reg   <= lpm_pkg::RST_FLASH_PD;
         sram_power_reg <= '1;
      end else begin
         flash_pd_reg   <= flash_pd_en;
         sram_power_reg <= sram_bank_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Autonomous peripherals and DMA

   // Kernel run enable: on in run, sleep and stop; off in standby
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         peri_run_reg <= '0;
      end else if (is_stby(mode_next)) begin
         peri_run_reg <= '0;
      end else if (is_stop(mode_next)) begin
         peri_run_reg <= peri_ok;
      end else begin
         peri_run_reg <= peri_en;
      end
   end

   // DMA transfers in stop 0 but only keeps state in stop 1
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dma_run_reg    <= 1'b0;
         dma_retain_reg <= 1'b0;
      end else begin
         dma_run_reg    <= dma_en && !is_stby(mode_next) &&
                           (mode_next != lpm_pkg::LPM_STOP1);
         dma_retain_reg <= dma_en &&
                           (mode_next == lpm_pkg::LPM_STOP1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // I/O state, retention and reset pin

   // Analog state holds until software configures the pins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         io_analog_reg     <= lpm_pkg::RST_IO_ANALOG;
         io_schmitt_en_reg <= 1'b0;
      end else if (io_config_done) begin
         io_analog_reg     <= 1'b0;
         io_schmitt_en_reg <= 1'b1;
      end
   end

   // Levels captured on standby entry stay after exit until released
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         io_pull_up_reg   <= '0;
         io_pull_down_reg <= '0;
      end else if (!in_stby && is_stby(mode_next)) begin
         if (io_retain_en) begin
            io_pull_up_reg   <= io_level;
            io_pull_down_reg <= ~io_level;
         end else begin
            io_pull_up_reg   <= '0;
            io_pull_down_reg <= '0;
         end
      end else if (io_release && !in_stby) begin
         io_pull_up_reg   <= '0;
         io_pull_down_reg <= '0;
      end
   end

   // Pull-up drops while an internal source holds reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reset_pullup_en_reg <= lpm_pkg::RST_RST_PULLUP;
      end else begin
         reset_pullup_en_reg <= !reset_internal;
      end
   end

   // Debug port gated by the debugger request only in standby
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         debug_access_port_zero_reg <= 1'b1;
      end else begin
         debug_access_port_zero_reg <= !is_stby(mode_next) ||
                                       dbg_req_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence stop1_idle_s;
      (mode_reg == lpm_pkg::LPM_STOP0) && !bus_clk_req &&
      lp_sel == lpm_pkg::LP_SEL_STOP1 && !peri_wake && !dma_wake &&
      !parity_wake;
   endsequence

   sequence stop_wake_s;
      in_stop && (peri_wake || parity_wake);
   endsequence

   flash_pd_follow_a: assert property (
      flash_pd_en[*2] |-> flash_pd_reg)
      else $error("flash power-down not applied");
   sram_switch_a: assert property (
      ##1 sram_power_reg == $past(sram_bank_en))
      else $error("sram bank switch wrong");
   hsi_demand_a: assert property (
      (mode_reg == lpm_pkg::LPM_STOP1 && mode_next == mode_reg &&
       !(|(peri_hsi_req & peri_ok)))
      |=> !internal_fast_oscillator_on_reg)
      else $error("internal oscillator left on");
   hse_radio_a: assert property (
      (mode_reg == lpm_pkg::LPM_STOP0 && mode_next == mode_reg)
      |=> external_fast_oscillator_on_reg == $past(radio_hse_req))
      else $error("external oscillator not following radio");
   pin_wake_a: assert property (
      (in_stby && pin_wake) |=> mode_reg == lpm_pkg::LPM_RUN
      ##0 wake_event_reg)
      else $error("wake pin ignored");
   io_hold_a: assert property (
      (!in_stby && is_stby(mode_next) && io_retain_en)
      |=> io_pull_up_reg == ~io_pull_down_reg)
      else $error("io retention pulls wrong");
   stop_wake_a: assert property (
      stop_wake_s |=> mode_reg == lpm_pkg::LPM_RUN && sys_clk_on_reg)
      else $error("stop not ended on wake request");
   dma_stop1_a: assert property (
      mode_reg == lpm_pkg::LPM_STOP1 |-> !dma_run_reg)
      else $error("dma running in stop 1");
   debug_gate_a: assert property (
      (in_stby && !dbg_req_s && mode_next == mode_reg)
      |=> !debug_access_port_zero_reg)
      else $error("debug port open without request");
   stop1_return_a: assert property (
      stop1_idle_s |=> mode_reg == lpm_pkg::LPM_STOP1)
      else $error("no return to stop 1");
   reset_pullup_a: assert property (
      reset_internal |=> !reset_pullup_en_reg)
      else $error("reset pull-up left on");
   parity_wake_a: assert property (
      (mode_reg == lpm_pkg::LPM_STOP1 && parity_wake)
      |=> parity_wake_reg && mode_reg == lpm_pkg::LPM_RUN)
      else $error("parity error did not wake");
   stby_off_a: assert property (
      in_stby |-> peri_run_reg == '0 && !dma_run_reg)
      else $error("peripheral on in standby");
   io_analog_a: assert property (
      io_analog_reg |-> !io_schmitt_en_reg)
      else $error("schmitt enabled in analog state");

endmodule // lpm_ctrl

//--- test/lpm_peri_model.sv
`timescale 1ns/100ps

module lpm_peri_model #(
   parameter int LEN = 4
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rstn,
   // Controller side
   input  wire logic [5:0] peri_run,
   input  wire logic       cpu_clk_on,
   // Bench trigger, one cycle per transfer
   input  wire logic [5:0] start,
   // Requests back to the controller
   output logic      [5:0] hsi_req,
   output logic      [5:0] wake_irq
);
   int cnt;

   ////////////////////////////////////////////////////////////////////////
   // A transfer holds the oscillator request for LEN cycles, then raises
   // its wake request; a stopped peripheral never requests anything
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt      <= 0;
         hsi_req  <= 6'h00;
         wake_irq <= 6'h00;
      end else begin
         if (cnt == 0 && start != 6'h00) begin
            hsi_req <= start & peri_run;
            cnt     <= LEN;
         end else if (cnt == 1) begin
            wake_irq <= hsi_req;
            hsi_req  <= 6'h00;
            cnt      <= 0;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
         // Request held until the core clock is back
         if (cpu_clk_on && cnt == 0)
            wake_irq <= 6'h00;
      end
   end
endmodule // lpm_peri_model

//--- test/lpm_ctrl_bench.sv
`timescale 1ns/100ps

module lpm_ctrl_bench;
   logic clock, rstn, lp_enter, flash_pd_en, hse_sw_en, bus_clk_req;
   logic radio_hse_req, dma_en, dma_wake_en, dma_wake_irq, io_retain_en;
   logic sram_parity_err, parity_irq_en, parity_nmi_en, io_release;
   logic io_config_done, debug_power_up_request, reset_internal;
   logic [2:0]  lp_sel;
   logic [1:0]  sram_bank_en, serial_mode_ok;
   logic [5:0]  peri_en, peri_wake_en, peri_wake_irq, peri_hsi_req, start;
   logic [7:0]  wake_pin, wake_pin_en;
   logic [19:0] io_level;
   lpm_pkg::lpm_mode_type mode_reg;
   logic cpu_clk_on_reg, sys_clk_on_reg, flash_pd_reg, dma_run_reg;
   logic internal_fast_oscillator_on_reg, external_fast_oscillator_on_reg;
   logic dma_retain_reg, wake_event_reg, parity_wake_reg, io_analog_reg;
   logic io_schmitt_en_reg, reset_pullup_en_reg, debug_access_port_zero_reg;
   logic [1:0]  sram_power_reg;
   logic [5:0]  peri_run_reg;
   logic [19:0] io_pull_up_reg, io_pull_down_reg;
   int          num_errors = 0;
   int          checks     = 0;

   lpm_ctrl lpm_ctrl_i (.*);

   lpm_peri_model lpm_peri_model_i (
      .clock      (clock),
      .rstn       (rstn),
      .peri_run   (peri_run_reg),
      .cpu_clk_on (cpu_clk_on_reg),
      .start      (start),
      .hsi_req    (peri_hsi_req),
      .wake_irq   (peri_wake_irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Inputs change on the falling edge, away from the sampling edge
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_mode(input lpm_pkg::lpm_mode_type exp);
      checks++;
      if (mode_reg !== exp) begin
         num_errors++;
         $display("unexpected at %0t: mode %0d want %0d", $time, mode_reg,
                  exp);
      end
   endtask

   // Bounded wait, since wake latency depends on the peripheral model
   task automatic wait_mode(input lpm_pkg::lpm_mode_type m);
      int n;
      n = 0;
      while (mode_reg !== m && n < 20) begin
         step(1);
         n++;
      end
      chk_mode(m);
   endtask

   task automatic enter(input logic [2:0] sel);
      lp_sel   = sel;
      lp_enter = 1'b1;
      step(1);
      lp_enter = 1'b0;
   endtask

   // One transfer of the peripherals in mask
   task automatic kick(input logic [5:0] mask);
      start = mask;
      step(1);
      start = 6'h00;
   endtask

   task automatic end_sim;
      if (num_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog, far above the hundred or so cycles the tests need
   initial begin
      #(40 * 3000);
      num_errors++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rstn, lp_enter, flash_pd_en, hse_sw_en, bus_clk_req} = 5'h00;
      {radio_hse_req, dma_en, dma_wake_en, dma_wake_irq, io_retain_en} = 5'h00;
      {sram_parity_err, parity_irq_en, parity_nmi_en, io_release} = 4'h0;
      {io_config_done, debug_power_up_request, reset_internal} = 3'h0;
      {lp_sel, sram_bank_en, serial_mode_ok, start} = 13'h0000;
      {peri_en, peri_wake_en, wake_pin, wake_pin_en} = 28'h0000000;
      sram_bank_en = 2'h3;
      io_level     = 20'hA5C3E;
      // Count rising edges so the reset length does not hang on time zero
      repeat (5) @(posedge clock);
      step(1);
      rstn = 1'b1;
      step(1);
      chk_mode(lpm_pkg::LPM_RUN);
      chk(flash_pd_reg, 1'b0);
      chk(sram_power_reg, 2'h3);
      chk(io_analog_reg, 1'b1);
      chk(io_schmitt_en_reg, 1'b0);
      chk(reset_pullup_en_reg, 1'b1);
      chk(external_fast_oscillator_on_reg, 1'b0);
      flash_pd_en    = 1'b1;
      sram_bank_en   = 2'h1;
      io_config_done = 1'b1;
      reset_internal = 1'b1;
      step(2);
      chk(flash_pd_reg, 1'b1);
      chk(sram_power_reg, 2'h1);
      chk(io_analog_reg, 1'b0);
      chk(reset_pullup_en_reg, 1'b0);
      {io_config_done, reset_internal} = 2'h0;
      enter(3'h6);
      chk_mode(lpm_pkg::LPM_RUN);
      // Stop 1 with the timer wake left disabled
      {peri_en, serial_mode_ok, peri_wake_en} = 14'h3FDF;
      {dma_en, dma_wake_en} = 2'h3;
      enter(lpm_pkg::LP_SEL_STOP1);
      chk_mode(lpm_pkg::LPM_STOP1);
      chk(cpu_clk_on_reg, 1'b0);
      chk(peri_run_reg, 6'h3F);
      chk(dma_retain_reg, 1'b1);
      chk(dma_run_reg, 1'b0);
      chk(internal_fast_oscillator_on_reg, 1'b0);
      kick(6'h20);
      step(2);
      chk(internal_fast_oscillator_on_reg, 1'b1);
      step(6);
      chk_mode(lpm_pkg::LPM_STOP1);
      chk(internal_fast_oscillator_on_reg, 1'b0);
      peri_wake_en = 6'h3F;
      wait_mode(lpm_pkg::LPM_RUN);
      chk(sys_clk_on_reg, 1'b1);
      for (int i = 0; i < 5; i++) begin
         enter(lpm_pkg::LP_SEL_STOP1);
         kick(6'h01 << i);
         wait_mode(lpm_pkg::LPM_RUN);
         chk(wake_event_reg, 1'b1);
      end
      // Serial ports outside their allowed modes stay stopped
      serial_mode_ok = 2'h0;
      enter(lpm_pkg::LP_SEL_STOP1);
      chk(peri_run_reg, 6'h3C);
      kick(6'h01);
      step(8);
      chk_mode(lpm_pkg::LPM_STOP1);
      sram_parity_err = 1'b1;
      step(3);
      chk_mode(lpm_pkg::LPM_STOP1);
      parity_nmi_en = 1'b1;
      wait_mode(lpm_pkg::LPM_RUN);
      chk(parity_wake_reg, 1'b1);
      {sram_parity_err, parity_nmi_en, serial_mode_ok} = 4'h3;
      // Bus clock request moves between the two stop modes
      enter(lpm_pkg::LP_SEL_STOP1);
      bus_clk_req = 1'b1;
      step(1);
      chk_mode(lpm_pkg::LPM_STOP0);
      chk(dma_run_reg, 1'b1);
      chk(internal_fast_oscillator_on_reg, 1'b1);
      radio_hse_req = 1'b1;
      step(1);
      chk(external_fast_oscillator_on_reg, 1'b1);
      radio_hse_req = 1'b0;
      step(1);
      chk(external_fast_oscillator_on_reg, 1'b0);
      bus_clk_req = 1'b0;
      step(1);
      chk_mode(lpm_pkg::LPM_STOP1);
      bus_clk_req = 1'b1;
      step(1);
      dma_wake_irq = 1'b1;
      wait_mode(lpm_pkg::LPM_RUN);
      {dma_wake_irq, bus_clk_req} = 2'h0;
      enter(lpm_pkg::LP_SEL_SLEEP);
      chk_mode(lpm_pkg::LPM_SLEEP);
      dma_wake_irq = 1'b1;
      wait_mode(lpm_pkg::LPM_RUN);
      dma_wake_irq = 1'b0;
      // Direct stop 0 entry keeps the software oscillator request out
      hse_sw_en = 1'b1;
      enter(lpm_pkg::LP_SEL_STOP0);
      chk_mode(lpm_pkg::LPM_STOP0);
      chk(external_fast_oscillator_on_reg, 1'b0);
      kick(6'h04);
      wait_mode(lpm_pkg::LPM_RUN);
      chk(external_fast_oscillator_on_reg, 1'b1);
      hse_sw_en = 1'b0;
      // Standby with retained pulls, one enabled wake pin
      {io_retain_en, wake_pin_en} = 9'h110;
      enter(lpm_pkg::LP_SEL_STBY_RET);
      chk_mode(lpm_pkg::LPM_STBY_RET);
      chk(io_pull_up_reg, io_level);
      chk(io_pull_down_reg, ~io_level);
      chk(debug_access_port_zero_reg, 1'b0);
      debug_power_up_request = 1'b1;
      step(4);
      chk(debug_access_port_zero_reg, 1'b1);
      debug_power_up_request = 1'b0;
      wake_pin = 8'h08;
      step(5);
      chk_mode(lpm_pkg::LPM_STBY_RET);
      wake_pin = 8'h18;
      wait_mode(lpm_pkg::LPM_RUN);
      wake_pin = 8'h00;
      chk(io_pull_up_reg, io_level);
      io_release = 1'b1;
      step(2);
      chk(io_pull_up_reg, 20'h00000);
      {io_release, io_retain_en} = 2'h0;
      step(3);
      enter(lpm_pkg::LP_SEL_STBY);
      chk_mode(lpm_pkg::LPM_STBY);
      chk(io_pull_down_reg, 20'h00000);
      wake_pin = 8'h10;
      wait_mode(lpm_pkg::LPM_RUN);
      end_sim();
   end
endmodule // lpm_ctrl_bench
